// file: inc/rx_ctrl_regs.svh
// Offsets, field positions, reset values and timing counts of the receiver control pair
`ifndef RX_CTRL_REGS_SVH
`define RX_CTRL_REGS_SVH
// ----------------------------------------
// Clock rates and times
// ----------------------------------------
`define CLK_HZ 100000000
`define REF_FAST_HZ 4096
`define REF_SLOW_HZ 1024
`define READY_TIME_MS 500
`define STRAP_WINDOW_MS 20
`define PD_MIN_TIME_US 2000
// ----------------------------------------
// Derived counts
// ----------------------------------------
`define READY_SLOW_EDGES ((`READY_TIME_MS * `REF_SLOW_HZ) / 1000)
`define READY_FAST_EDGES ((`READY_TIME_MS * `REF_FAST_HZ) / 1000)
`define STRAP_WINDOW_EDGES ((`STRAP_WINDOW_MS * `REF_SLOW_HZ) / 1000)
`define PROBE_LOW_EDGES 2
`define PROBE_HIGH_EDGES 4
`define AGC_HOLD_MAX_EDGES 256
`define PD_MIN_CYC ((`PD_MIN_TIME_US * (`CLK_HZ / 1000000) + 0))
`define REF_HALF_FAST_CYC (`CLK_HZ / (2 * `REF_FAST_HZ))
`define REF_HALF_SLOW_CYC (`CLK_HZ / (2 * `REF_SLOW_HZ))
// ----------------------------------------
// Host register map
// ----------------------------------------
`define CTRL_OFS 8'h00
`define SEL_OFS 8'h04
`define STATUS_OFS 8'h08
`define CTRL_PD_BIT 0
`define CTRL_HOLD_BIT 1
`define CTRL_RATE_BIT 2
`define CTRL_RESET 3'h3
`define SEL_RESET 4'h2
// ----------------------------------------
// Capacitor current settings
// ----------------------------------------
`define DEM_CUR_40K 2'h0
`define DEM_CUR_60K 2'h1
`define DEM_CUR_77K 2'h2
`define DEM_CUR_TEST 2'h3
`define PK_CUR_40K 2'h0
`define PK_CUR_60K 2'h1
`define PK_CUR_77K 2'h2
`define PK_CUR_TEST 2'h3
`endif

// file: inc/rx_ctrl_pkg.sv
// Types shared by the receiver control ends
package rx_ctrl_pkg;
  typedef enum logic [1:0] {STRAP_LOW, STRAP_HIGH, STRAP_OPEN} strap_t;
  typedef enum logic [3:0] {PROTO_NONE, PROTO_JJY40, PROTO_WWVB, PROTO_JJY60, PROTO_MSF,
                            PROTO_DCF77, PROTO_TEST_A, PROTO_TEST_B, PROTO_INVALID} protocol_t;
  typedef enum logic [2:0] {DS_POWER_DOWN, DS_PROBE_LOW, DS_PROBE_HIGH, DS_RESOLVE,
                            DS_ACTIVE, DS_FAULT} dev_state_t;
  typedef enum logic {HS_DOWN, HS_UP} host_state_t;
  typedef logic [1:0] current_sel_t;
endpackage

// file: inc/rx_link_if.sv
// Control pins between host controller and receiver
interface rx_link_if;
  logic power_down_request;
  logic gain_hold_request;
  logic ref_clock;
  logic clock_rate_sel;
  logic sel_a_drive;
  logic sel_a_drive_oe;
  logic sel_b_drive;
  logic sel_b_drive_oe;
  logic sel_a_pull;
  logic sel_a_pull_oe;
  logic sel_b_pull;
  logic sel_b_pull_oe;
  logic station_select_a;
  logic station_select_b;
  // Strong host drive beats the weak probe pull; an unpulled open pin reads low
  assign station_select_a = sel_a_drive_oe ? sel_a_drive : (sel_a_pull_oe ? sel_a_pull : 1'b0);
  assign station_select_b = sel_b_drive_oe ? sel_b_drive : (sel_b_pull_oe ? sel_b_pull : 1'b0);
  modport device (input power_down_request, input gain_hold_request, input ref_clock,
                  input clock_rate_sel, input station_select_a, input station_select_b,
                  output sel_a_pull, output sel_a_pull_oe, output sel_b_pull, output sel_b_pull_oe);
  modport host (output power_down_request, output gain_hold_request, output ref_clock,
                output clock_rate_sel, output sel_a_drive, output sel_a_drive_oe,
                output sel_b_drive, output sel_b_drive_oe);
endinterface // rx_link_if

// file: verilog/strap_resolver.sv
// Three-state resolution of one strap pin from two probe samples
module strap_resolver (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Probe
  input wire logic pin_sync,
  input wire logic cap_low,
  input wire logic cap_high,
  // Result
  output rx_ctrl_pkg::strap_t level
);
  logic low_q;
  logic high_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
      high_q <= 1'b0;
    end else begin
      if (cap_low) begin
        low_q <= pin_sync;
      end
      if (cap_high) begin
        high_q <= pin_sync;
      end
    end
  end

  // Pin that follows the pull is open
  assign level = (low_q != high_q) ? rx_ctrl_pkg::STRAP_OPEN :
                 (high_q ? rx_ctrl_pkg::STRAP_HIGH : rx_ctrl_pkg::STRAP_LOW);
endmodule // strap_resolver

// file: verilog/receiver_ctrl.sv
// Receiver end: power sequencing, strap latching and AGC hold control
`include "rx_ctrl_regs.svh"

module receiver_ctrl #(
  parameter int AGC_HOLD_MAX = `AGC_HOLD_MAX_EDGES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Link pins
  rx_link_if.device LINK,
  // Read-out activity from the data path
  input wire logic READOUT_BUSY,
  // Status
  output logic RX_ACTIVE,
  output logic RX_READY,
  output logic SELECT_FAULT,
  output logic CLK_RATE_HIGH,
  output rx_ctrl_pkg::protocol_t PROTOCOL,
  // Analog steering
  output rx_ctrl_pkg::current_sel_t DEM_CURRENT_SEL,
  output rx_ctrl_pkg::current_sel_t PK_CURRENT_SEL,
  output logic AGC_HOLD
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (AGC_HOLD_MAX < 1 || AGC_HOLD_MAX > 4095) begin : g_bad_hold
    $error("AGC_HOLD_MAX out of range");
  end
  if (`PROBE_HIGH_EDGES > `STRAP_WINDOW_EDGES) begin : g_bad_window
    $error("Strap probe exceeds sampling window");
  end

  localparam logic [11:0] READY_SLOW_LAST = 12'(`READY_SLOW_EDGES - 1);
  localparam logic [11:0] READY_FAST_LAST = 12'(`READY_FAST_EDGES - 1);
  localparam logic [11:0] PROBE_LOW_LAST = 12'(`PROBE_LOW_EDGES - 1);
  localparam logic [11:0] PROBE_HIGH_LAST = 12'(`PROBE_HIGH_EDGES - 1);
  localparam logic [11:0] HOLD_MAX = 12'(AGC_HOLD_MAX);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic ref_prev_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_q <= 6'h01;
      sync2_q <= 6'h01;
      ref_prev_q <= 1'b0;
    end else begin
      sync1_q <= {LINK.clock_rate_sel, LINK.station_select_b, LINK.station_select_a,
                  LINK.ref_clock, LINK.gain_hold_request, LINK.power_down_request};
      sync2_q <= sync1_q;
      ref_prev_q <= sync2_q[2];
    end
  end

  wire pd_req = sync2_q[0];
  wire hold_low = ~sync2_q[1];
  wire ref_edge = sync2_q[2] & ~ref_prev_q;
  wire [1:0] sel_lvl = sync2_q[4:3];
  wire rate_lvl = sync2_q[5];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  rx_ctrl_pkg::dev_state_t state_q;
  rx_ctrl_pkg::dev_state_t state_d;
  logic [11:0] wake_cnt_q;
  logic [11:0] wake_cnt_d;
  logic rate_fast_q;

  wire cap_low = (state_q == rx_ctrl_pkg::DS_PROBE_LOW) && ref_edge && (wake_cnt_q == PROBE_LOW_LAST);
  wire cap_high = (state_q == rx_ctrl_pkg::DS_PROBE_HIGH) && ref_edge && (wake_cnt_q == PROBE_HIGH_LAST);
  wire [11:0] ready_last = rate_fast_q ? READY_FAST_LAST : READY_SLOW_LAST;
  wire ready_hit = (state_q == rx_ctrl_pkg::DS_ACTIVE) && ref_edge && (wake_cnt_q == ready_last);

  // ----------------------------------------
  // Strap resolution
  // ----------------------------------------
  rx_ctrl_pkg::strap_t strap_lvl [2];

  for (genvar i = 0; i < 2; i++) begin : g_strap
    strap_resolver u_strap (
      .clk(CLK),
      .rst_n(RESET_N),
      .pin_sync(sel_lvl[i]),
      .cap_low(cap_low),
      .cap_high(cap_high),
      .level(strap_lvl[i])
    );
  end

  function automatic rx_ctrl_pkg::protocol_t decode_proto(rx_ctrl_pkg::strap_t a, rx_ctrl_pkg::strap_t b);
    rx_ctrl_pkg::protocol_t p;
    p = rx_ctrl_pkg::PROTO_INVALID;
    case ({a, b})
      {rx_ctrl_pkg::STRAP_LOW, rx_ctrl_pkg::STRAP_LOW}: p = rx_ctrl_pkg::PROTO_JJY40;
      {rx_ctrl_pkg::STRAP_LOW, rx_ctrl_pkg::STRAP_HIGH}: p = rx_ctrl_pkg::PROTO_WWVB;
      {rx_ctrl_pkg::STRAP_HIGH, rx_ctrl_pkg::STRAP_LOW}: p = rx_ctrl_pkg::PROTO_JJY60;
      {rx_ctrl_pkg::STRAP_HIGH, rx_ctrl_pkg::STRAP_HIGH}: p = rx_ctrl_pkg::PROTO_MSF;
      {rx_ctrl_pkg::STRAP_OPEN, rx_ctrl_pkg::STRAP_LOW}: p = rx_ctrl_pkg::PROTO_DCF77;
      {rx_ctrl_pkg::STRAP_OPEN, rx_ctrl_pkg::STRAP_HIGH}: p = rx_ctrl_pkg::PROTO_DCF77;
      {rx_ctrl_pkg::STRAP_LOW, rx_ctrl_pkg::STRAP_OPEN}: p = rx_ctrl_pkg::PROTO_TEST_A;
      {rx_ctrl_pkg::STRAP_HIGH, rx_ctrl_pkg::STRAP_OPEN}: p = rx_ctrl_pkg::PROTO_TEST_B;
      default: p = rx_ctrl_pkg::PROTO_INVALID;
    endcase
    return p;
  endfunction

  function automatic logic [3:0] decode_current(rx_ctrl_pkg::protocol_t p);
    logic [3:0] c;
    c = {`DEM_CUR_TEST, `PK_CUR_TEST};
    case (p)
      rx_ctrl_pkg::PROTO_JJY40: c = {`DEM_CUR_40K, `PK_CUR_40K};
      rx_ctrl_pkg::PROTO_WWVB: c = {`DEM_CUR_60K, `PK_CUR_60K};
      rx_ctrl_pkg::PROTO_JJY60: c = {`DEM_CUR_60K, `PK_CUR_60K};
      rx_ctrl_pkg::PROTO_MSF: c = {`DEM_CUR_60K, `PK_CUR_60K};
      rx_ctrl_pkg::PROTO_DCF77: c = {`DEM_CUR_77K, `PK_CUR_77K};
      default: c = {`DEM_CUR_TEST, `PK_CUR_TEST};
    endcase
    return c;
  endfunction

  // Strap A is the first of the pair in the encoding
  wire rx_ctrl_pkg::protocol_t proto_dec = decode_proto(strap_lvl[0], strap_lvl[1]);
  wire [3:0] cur_dec = decode_current(proto_dec);

  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    if (pd_req) begin
      // Request doubles as reset of the whole sequence
      state_d = rx_ctrl_pkg::DS_POWER_DOWN;
      wake_cnt_d = 12'h000;
    end else begin
      case (state_q)
        rx_ctrl_pkg::DS_POWER_DOWN: begin
          state_d = rx_ctrl_pkg::DS_PROBE_LOW;
          wake_cnt_d = 12'h000;
        end
        rx_ctrl_pkg::DS_PROBE_LOW: begin
          if (ref_edge) begin
            wake_cnt_d = wake_cnt_q + 12'h001;
          end
          if (cap_low) begin
            state_d = rx_ctrl_pkg::DS_PROBE_HIGH;
          end
        end
        rx_ctrl_pkg::DS_PROBE_HIGH: begin
          if (ref_edge) begin
            wake_cnt_d = wake_cnt_q + 12'h001;
          end
          if (cap_high) begin
            state_d = rx_ctrl_pkg::DS_RESOLVE;
          end
        end
        rx_ctrl_pkg::DS_RESOLVE: begin
          state_d = (proto_dec == rx_ctrl_pkg::PROTO_INVALID) ? rx_ctrl_pkg::DS_FAULT : rx_ctrl_pkg::DS_ACTIVE;
        end
        rx_ctrl_pkg::DS_ACTIVE: begin
          if (ref_edge && (wake_cnt_q != ready_last)) begin
            wake_cnt_d = wake_cnt_q + 12'h001;
          end
        end
        rx_ctrl_pkg::DS_FAULT: begin
          state_d = rx_ctrl_pkg::DS_FAULT;
        end
        default: begin
          state_d = rx_ctrl_pkg::DS_POWER_DOWN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // AGC hold
  // ----------------------------------------
  // Manual hold is time limited so a stuck pin cannot freeze the AGC forever
  logic [11:0] hold_cnt_q;
  wire manual_hold = hold_low && (hold_cnt_q < HOLD_MAX);
  wire active_now = (state_q == rx_ctrl_pkg::DS_ACTIVE);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_cnt_q <= 12'h000;
    end else if (!hold_low || !active_now) begin
      hold_cnt_q <= 12'h000;
    end else if (ref_edge && manual_hold) begin
      hold_cnt_q <= hold_cnt_q + 12'h001;
    end
  end

  // ----------------------------------------
  // State and latched selection
  // ----------------------------------------
  logic pull_oe_q;
  logic pull_val_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= rx_ctrl_pkg::DS_POWER_DOWN;
      wake_cnt_q <= 12'h000;
      rate_fast_q <= 1'b0;
      PROTOCOL <= rx_ctrl_pkg::PROTO_NONE;
      DEM_CURRENT_SEL <= `DEM_CUR_TEST;
      PK_CURRENT_SEL <= `PK_CUR_TEST;
      SELECT_FAULT <= 1'b0;
      RX_READY <= 1'b0;
      RX_ACTIVE <= 1'b0;
      AGC_HOLD <= 1'b0;
      pull_oe_q <= 1'b0;
      pull_val_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
      pull_oe_q <= (state_d == rx_ctrl_pkg::DS_PROBE_LOW) || (state_d == rx_ctrl_pkg::DS_PROBE_HIGH);
      pull_val_q <= (state_d == rx_ctrl_pkg::DS_PROBE_HIGH);
      RX_ACTIVE <= (state_d == rx_ctrl_pkg::DS_ACTIVE);
      AGC_HOLD <= (state_d == rx_ctrl_pkg::DS_ACTIVE) && (manual_hold || READOUT_BUSY);
      if (pd_req) begin
        // Clock may be stopped from here on, nothing waits for an edge
        PROTOCOL <= rx_ctrl_pkg::PROTO_NONE;
        SELECT_FAULT <= 1'b0;
        RX_READY <= 1'b0;
      end else begin
        if (cap_high) begin
          rate_fast_q <= rate_lvl;
        end
        if (state_q == rx_ctrl_pkg::DS_RESOLVE) begin
          PROTOCOL <= proto_dec;
          SELECT_FAULT <= (proto_dec == rx_ctrl_pkg::PROTO_INVALID);
          DEM_CURRENT_SEL <= cur_dec[3:2];
          PK_CURRENT_SEL <= cur_dec[1:0];
        end
        if (ready_hit) begin
          RX_READY <= 1'b1;
        end
      end
    end
  end

  assign CLK_RATE_HIGH = rate_fast_q;
  assign LINK.sel_a_pull = pull_val_q;
  assign LINK.sel_a_pull_oe = pull_oe_q;
  assign LINK.sel_b_pull = pull_val_q;
  assign LINK.sel_b_pull_oe = pull_oe_q;
endmodule // receiver_ctrl

// file: verilog/host_ctrl.sv
// Host end: Wishbone registers driving the receiver control pins
`include "rx_ctrl_regs.svh"

module host_ctrl #(
  parameter int REF_HALF_FAST = `REF_HALF_FAST_CYC,
  parameter int REF_HALF_SLOW = `REF_HALF_SLOW_CYC,
  parameter int PD_MIN = `PD_MIN_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Link pins
  rx_link_if.host LINK
);
  if (REF_HALF_FAST < 1 || REF_HALF_SLOW < 1 || REF_HALF_FAST > 65535 || REF_HALF_SLOW > 65535) begin : g_bad_div
    $error("Reference divider out of range");
  end
  if (PD_MIN < 1 || PD_MIN > 262143) begin : g_bad_pd
    $error("PD_MIN out of range");
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  logic [2:0] ctrl_q;
  logic [3:0] sel_q;
  wire wb_hit = WB_CYC & WB_STB & ~WB_ACK;
  wire wb_wr = wb_hit & WB_WE & WB_SEL[0];
  wire ctrl_wr = wb_wr && (WB_ADR == `CTRL_OFS);
  wire sel_wr = wb_wr && (WB_ADR == `SEL_OFS);
  // Any strap change needs a fresh power-down to be latched
  wire reselect = (sel_wr && (WB_DAT_I[3:0] != sel_q)) ||
                  (ctrl_wr && (WB_DAT_I[`CTRL_RATE_BIT] != ctrl_q[`CTRL_RATE_BIT]));

  // ----------------------------------------
  // Power sequence and reference clock
  // ----------------------------------------
  rx_ctrl_pkg::host_state_t state_q;
  logic [17:0] pd_cnt_q;
  logic [15:0] div_cnt_q;
  logic ref_q;
  wire min_done = (pd_cnt_q == 18'(PD_MIN));
  wire [15:0] half_last = ctrl_q[`CTRL_RATE_BIT] ? 16'(REF_HALF_FAST - 1) : 16'(REF_HALF_SLOW - 1);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // Reset acts as supply turn-on: power-down is held from here
      state_q <= rx_ctrl_pkg::HS_DOWN;
      pd_cnt_q <= 18'h00000;
      div_cnt_q <= 16'h0000;
      ref_q <= 1'b0;
    end else begin
      case (state_q)
        rx_ctrl_pkg::HS_DOWN: begin
          div_cnt_q <= 16'h0000;
          ref_q <= 1'b0;
          if (reselect) begin
            pd_cnt_q <= 18'h00000;
          end else if (!min_done) begin
            pd_cnt_q <= pd_cnt_q + 18'h00001;
          end else if (!ctrl_q[`CTRL_PD_BIT]) begin
            state_q <= rx_ctrl_pkg::HS_UP;
          end
        end
        rx_ctrl_pkg::HS_UP: begin
          if (ctrl_q[`CTRL_PD_BIT] || reselect) begin
            // Sleep through the pin, never by dropping supply
            state_q <= rx_ctrl_pkg::HS_DOWN;
            pd_cnt_q <= 18'h00000;
          end else if (div_cnt_q >= half_last) begin
            div_cnt_q <= 16'h0000;
            ref_q <= ~ref_q;
          end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= rx_ctrl_pkg::HS_DOWN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  wire [31:0] rd_data = (WB_ADR == `CTRL_OFS) ? {29'h0, ctrl_q} :
                        (WB_ADR == `SEL_OFS) ? {28'h0, sel_q} :
                        (WB_ADR == `STATUS_OFS) ? {29'h0, (state_q == rx_ctrl_pkg::HS_UP), min_done,
                                                   (state_q == rx_ctrl_pkg::HS_DOWN)} : 32'h0;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= `CTRL_RESET;
      sel_q <= `SEL_RESET;
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK <= wb_hit;
      WB_DAT_O <= wb_hit ? rd_data : 32'h0;
      if (ctrl_wr) begin
        ctrl_q <= WB_DAT_I[2:0];
      end
      if (sel_wr) begin
        sel_q <= WB_DAT_I[3:0];
      end
    end
  end

  // Strap mode per pin: 0 low, 1 high, 2 or 3 left open
  assign LINK.power_down_request = (state_q == rx_ctrl_pkg::HS_DOWN);
  assign LINK.gain_hold_request = ctrl_q[`CTRL_HOLD_BIT];
  assign LINK.ref_clock = ref_q;
  assign LINK.clock_rate_sel = ctrl_q[`CTRL_RATE_BIT];
  assign LINK.sel_a_drive = sel_q[0];
  assign LINK.sel_a_drive_oe = ~sel_q[1];
  assign LINK.sel_b_drive = sel_q[2];
  assign LINK.sel_b_drive_oe = ~sel_q[3];
endmodule // host_ctrl

// file: bench/receiver_mode_latch_power_control_sva.sv
// Concurrent checks on the link between host and receiver control ends
module receiver_mode_latch_power_control_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Link pins
  input wire logic power_down_request,
  input wire logic gain_hold_request,
  input wire logic ref_clock,
  input wire logic clock_rate_sel,
  input wire logic sel_a_pull_oe,
  input wire logic sel_b_pull_oe,
  // Device status
  input wire logic READOUT_BUSY,
  input wire logic RX_ACTIVE,
  input wire logic RX_READY,
  input wire logic SELECT_FAULT,
  input wire logic CLK_RATE_HIGH,
  input wire rx_ctrl_pkg::protocol_t PROTOCOL,
  input wire rx_ctrl_pkg::current_sel_t DEM_CURRENT_SEL,
  input wire rx_ctrl_pkg::current_sel_t PK_CURRENT_SEL,
  input wire logic AGC_HOLD
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  function automatic rx_ctrl_pkg::current_sel_t cur_of(rx_ctrl_pkg::protocol_t p);
    case (p)
      rx_ctrl_pkg::PROTO_JJY40: return 2'h0;
      rx_ctrl_pkg::PROTO_DCF77: return 2'h2;
      rx_ctrl_pkg::PROTO_TEST_A, rx_ctrl_pkg::PROTO_TEST_B: return 2'h3;
      default: return 2'h1;
    endcase
  endfunction

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Margin covers the two sync flops and the state register
  sequence s_down_held;
    power_down_request [*8] ##1 power_down_request;
  endsequence
  sequence s_wake;
    $fell(power_down_request);
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_down_clears: assert property (s_down_held |-> !RX_ACTIVE && PROTOCOL == rx_ctrl_pkg::PROTO_NONE)
    else $error("receiver still active in power-down");
  a_clock_stopped: assert property (s_down_held |-> !ref_clock)
    else $error("reference clock running in power-down");
  a_probe_pull: assert property (s_wake |-> ##[1:10] (sel_a_pull_oe && sel_b_pull_oe))
    else $error("strap probe pull missing after wake");
  a_latch_stable: assert property (RX_ACTIVE && $past(RX_ACTIVE) |-> $stable(PROTOCOL) && $stable(CLK_RATE_HIGH))
    else $error("latched selection changed while awake");
  a_rate_match: assert property ($rose(RX_ACTIVE) |-> CLK_RATE_HIGH == clock_rate_sel)
    else $error("latched clock rate differs from strap");
  a_current_map: assert property (RX_ACTIVE |-> DEM_CURRENT_SEL == cur_of(PROTOCOL) && PK_CURRENT_SEL == cur_of(PROTOCOL))
    else $error("capacitor current does not follow protocol");
  a_fault_idle: assert property (SELECT_FAULT |-> !RX_ACTIVE && !RX_READY)
    else $error("receiver active with prohibited selection");
  a_ready_active: assert property (RX_READY |-> RX_ACTIVE)
    else $error("ready without active receiver");
  a_readout_hold: assert property ((RX_ACTIVE && READOUT_BUSY) [*2] |=> AGC_HOLD)
    else $error("no gain hold during read-out");
  a_agc_free: assert property ((RX_ACTIVE && gain_hold_request && !READOUT_BUSY) [*4] |-> !AGC_HOLD)
    else $error("gain held with hold request released");
  a_idle_no_hold: assert property (!RX_ACTIVE [*3] |-> !AGC_HOLD)
    else $error("gain hold while receiver stopped");
endmodule // receiver_mode_latch_power_control_sva

// file: bench/receiver_mode_latch_power_control_test.sv
// Self-checking bench joining the host and receiver control ends
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(c, n) for (k = 0; k < (n) && !(c); k++) @(posedge clk); \
  if (!(c)) fail_wait();

module receiver_mode_latch_power_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic readout_busy = 1'b0;
  logic rx_active, rx_ready, select_fault, clk_rate_high, agc_hold;
  rx_ctrl_pkg::protocol_t protocol;
  rx_ctrl_pkg::current_sel_t dem_cur, pk_cur;
  rx_ctrl_pkg::protocol_t exp_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_edge = 0;
  int k, e0;
  logic [31:0] rd;
  logic [31:0] seed = 32'h00004443;
  logic ref_q = 1'b0;
  logic [1:0] h;

  rx_link_if lnk ();
  host_ctrl #(.REF_HALF_FAST(4), .REF_HALF_SLOW(8), .PD_MIN(50)) i_host_ctrl (.CLK(clk), .RESET_N(rst_n),
    .WB_CYC(wb_cyc), .WB_STB(wb_stb), .WB_WE(wb_we), .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK(wb_ack), .LINK(lnk));
  receiver_ctrl #(.AGC_HOLD_MAX(4)) i_receiver_ctrl (.CLK(clk), .RESET_N(rst_n), .LINK(lnk),
    .READOUT_BUSY(readout_busy), .RX_ACTIVE(rx_active), .RX_READY(rx_ready), .SELECT_FAULT(select_fault),
    .CLK_RATE_HIGH(clk_rate_high), .PROTOCOL(protocol), .DEM_CURRENT_SEL(dem_cur), .PK_CURRENT_SEL(pk_cur),
    .AGC_HOLD(agc_hold));
  receiver_mode_latch_power_control_sva i_receiver_mode_latch_power_control_sva (.CLK(clk), .RESET_N(rst_n),
    .power_down_request(lnk.power_down_request), .gain_hold_request(lnk.gain_hold_request),
    .ref_clock(lnk.ref_clock), .clock_rate_sel(lnk.clock_rate_sel), .sel_a_pull_oe(lnk.sel_a_pull_oe),
    .sel_b_pull_oe(lnk.sel_b_pull_oe), .READOUT_BUSY(readout_busy), .RX_ACTIVE(rx_active),
    .RX_READY(rx_ready), .SELECT_FAULT(select_fault), .CLK_RATE_HIGH(clk_rate_high), .PROTOCOL(protocol),
    .DEM_CURRENT_SEL(dem_cur), .PK_CURRENT_SEL(pk_cur), .AGC_HOLD(agc_hold));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Reference edges since wake, counted on the link itself
  // ----------------------------------------
  always @(posedge clk) begin
    ref_q <= lnk.ref_clock;
    if (lnk.power_down_request !== 1'b0) begin
      n_edge <= 0;
    end else if (lnk.ref_clock === 1'b1 && ref_q === 1'b0) begin
      n_edge <= n_edge + 1;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Strap index 0 low, 1 high, 2 open
  function automatic rx_ctrl_pkg::protocol_t exp_proto(int a, int b);
    case (a * 3 + b)
      0: return rx_ctrl_pkg::PROTO_JJY40;
      1: return rx_ctrl_pkg::PROTO_WWVB;
      2: return rx_ctrl_pkg::PROTO_TEST_A;
      3: return rx_ctrl_pkg::PROTO_JJY60;
      4: return rx_ctrl_pkg::PROTO_MSF;
      5: return rx_ctrl_pkg::PROTO_TEST_B;
      6, 7: return rx_ctrl_pkg::PROTO_DCF77;
      default: return rx_ctrl_pkg::PROTO_INVALID;
    endcase
  endfunction

  function automatic logic [1:0] exp_cur(rx_ctrl_pkg::protocol_t p);
    case (p)
      rx_ctrl_pkg::PROTO_JJY40: return 2'h0;
      rx_ctrl_pkg::PROTO_DCF77: return 2'h2;
      rx_ctrl_pkg::PROTO_TEST_A, rx_ctrl_pkg::PROTO_TEST_B: return 2'h3;
      default: return 2'h1;
    endcase
  endfunction

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_wait();
    n_mismatch++;
    $display("mismatch wait expected done seen timeout");
    conclude();
  endtask

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_i <= d;
    for (i = 0; i < 20 && wb_ack !== 1'b1; i++) @(posedge clk);
    if (wb_ack !== 1'b1) fail_wait();
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Power-down, new straps, wake, compare against the model
  task automatic run(input int a, input int b, input logic rate);
    rx_ctrl_pkg::protocol_t e;
    wb(1'b1, 8'h00, {29'h0, rate, 2'h3}, 4'hF);
    `WAITC(rx_active === 1'b0 && select_fault === 1'b0, 200)
    `CHK("protocol_down", rx_ctrl_pkg::PROTO_NONE, protocol)
    wb(1'b1, 8'h04, {28'h0, 2'(b), 2'(a)}, 4'hF);
    exp_q.push_back(exp_proto(a, b));
    wb(1'b1, 8'h00, {29'h0, rate, 2'h2}, 4'hF);
    `WAITC(rx_active === 1'b1 || select_fault === 1'b1, 3000)
    e = exp_q.pop_front();
    if (e == rx_ctrl_pkg::PROTO_INVALID) begin
      `CHK("fault", 1'b1, select_fault)
    end else begin
      `CHK("protocol", e, protocol)
      `CHK("dem_current", exp_cur(e), dem_cur)
      `CHK("pk_current", exp_cur(e), pk_cur)
      `CHK("clock_rate", rate, clk_rate_high)
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK("ctrl_reset", 32'h00000003, rd)
    wb(1'b1, 8'h04, 32'h00000005, 4'h0);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    `CHK("sel_reset", 32'h00000002, rd)
    wb(1'b0, 8'hFC, 32'h0, 4'hF);
    `CHK("unmapped", 32'h00000000, rd)
    wb(1'b0, 8'h08, 32'h0, 4'hF);
    `CHK("status_down", 1'b1, rd[0])
    `CHK("ref_stopped", 1'b0, lnk.ref_clock)
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        run(a, b, 1'(xs()));
      end
    end
    // Ready counted in reference edges at each rate
    for (int r = 0; r < 2; r++) begin
      run(0, 1, 1'(r));
      `WAITC(rx_ready === 1'b1, 40000)
      `CHK("ready_edges", (r == 1) ? 2048 : 512, n_edge)
    end
    // Manual hold is brief: released after a few reference edges
    wb(1'b1, 8'h00, 32'h00000004, 4'hF);
    repeat (6) @(posedge clk);
    `CHK("agc_hold", 1'b1, agc_hold)
    e0 = n_edge;
    `WAITC(n_edge >= e0 + 6, 200)
    repeat (4) @(posedge clk);
    `CHK("agc_release", 1'b0, agc_hold)
    wb(1'b1, 8'h00, 32'h00000006, 4'hF);
    repeat (6) @(posedge clk);
    // Random read-out activity; hold follows it one cycle later
    h = 2'h0;
    for (int c = 0; c < 40; c++) begin
      @(posedge clk);
      if (c > 1) `CHK("agc_readout", h[1], agc_hold)
      h = {h[0], 1'(xs())};
      readout_busy <= h[0];
    end
    // Let the last random value stand for one edge before idling
    @(posedge clk);
    readout_busy <= 1'b0;
    run(2, 0, 1'b0);
    conclude();
  end
endmodule // receiver_mode_latch_power_control_test
